// >>> dv/clko_divider_checker.sv
// Port assertions for the clock output divider
`timescale 1ns/100ps
`default_nettype none
module clko_divider_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic clock_enable,
  input wire logic [1:0] pin_select,
  input wire logic clk_out,
  input wire logic [1:0] pin_route
);
  logic wr_go;
  logic last_ff;
  logic [7:0] rest_ff;
  logic [7:0] still_ff;
  assign wr_go = s_axi_awvalid && s_axi_awready;
  // Idle and still counters; a write restarts both since invert acts at once
  always_ff @(posedge aclk) begin
    last_ff <= clk_out;
    if (!aresetn || clock_enable || wr_go) begin
      rest_ff <= 8'h00;
    end else if (rest_ff != 8'hff) begin
      rest_ff <= rest_ff + 8'h01;
    end
    if (!aresetn || !clock_enable || wr_go || clk_out != last_ff) begin
      still_ff <= 8'h00;
    end else if (still_ff != 8'hff) begin
      still_ff <= still_ff + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  route_follows_a: assert property (pin_route == pin_select)
    else $error("pin route differs from pin select");
  rest_level_a: assert property (rest_ff >= 8'hc8 |-> $stable(clk_out))
    else $error("output moves after the generator stopped");
  keeps_toggling_a: assert property (still_ff < 8'h64)
    else $error("output stuck while enabled");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready
      && !s_axi_wready)
    else $error("write accepted while response pending");
  write_answer_a: assert property (wr_go && s_axi_wvalid && s_axi_wready
      |-> ##[2:4] s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
    else $error("read response late");
  cover property (wr_go);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(clk_out) && clock_enable);
endmodule // clko_divider_checker
`default_nettype wire

// >>> dv/clko_sink.sv
// Receiving-chip model that times the generated clock
`timescale 1ns/100ps
`default_nettype none
module clko_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_in,
  output logic [31:0] rise_cnt_ff,
  output logic [31:0] high_cnt_ff
);
  logic last_ff;
  // Passive receiver: counts rising edges and high cycles, demands nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_ff <= 1'b0;
      rise_cnt_ff <= 32'h0000_0000;
      high_cnt_ff <= 32'h0000_0000;
    end else begin
      last_ff <= clk_in;
      rise_cnt_ff <= rise_cnt_ff + 32'(clk_in && !last_ff);
      high_cnt_ff <= high_cnt_ff + 32'(clk_in);
    end
  end
endmodule // clko_sink
`default_nettype wire

// >>> dv/test_programmable_clock_output_divider.sv
// Self-checking bench for the clock output divider
`timescale 1ns/100ps
`default_nettype none
`include "clko_params.svh"
module test_programmable_clock_output_divider;
  import clko_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, clock_enable = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, clk_out;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  clko_addr_t s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rise_cnt, high_cnt;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, pin_select = 2'h0, pin_route;
  int n_fail = 0, n_compared = 0, n_cyc = 0;
  clko_divider dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .clock_enable, .pin_select, .clk_out,
    .pin_route);
  clko_sink sink (.aclk, .aresetn, .clk_in(clk_out), .rise_cnt_ff(rise_cnt),
    .high_cnt_ff(high_cnt));
  ////////////////////////////////////////////////////////////////////////
  // Clock and a watchdog sized well above the whole run
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 40000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Tolerance absorbs the oscillator's 2 or 3 cycle half periods
  task automatic check(input string what, input logic [31:0] seen, exp,
      input logic [31:0] tol = 0);
    n_compared++;
    if (!(seen === exp || (!$isunknown(seen) && seen + tol >= exp
        && seen <= exp + tol))) begin
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
      n_fail++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Bus master; readies and answers are sampled mid-cycle, where settled
  task automatic axi_wr(input clko_addr_t a, input logic [7:0] d,
      output logic [1:0] r);
    logic aw_go, w_go;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_go = 1'b0;
    w_go = 1'b0;
    while (!(aw_go && w_go)) begin
      @(negedge aclk);
      aw_go |= s_axi_awvalid && s_axi_awready;
      w_go |= s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input clko_addr_t a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_rise();
    logic [31:0] r0;
    @(negedge aclk);
    r0 = rise_cnt;
    do @(negedge aclk); while (rise_cnt == r0);
  endtask
  // Six periods span exactly 25 cycles per division step
  task automatic measure(output logic [31:0] p, h);
    logic [31:0] c0, h0;
    wait_rise();
    c0 = n_cyc;
    h0 = high_cnt;
    repeat (6) wait_rise();
    p = n_cyc - c0;
    h = high_cnt - h0;
  endtask
  task automatic fall_time(input logic [31:0] c0, output logic [31:0] p);
    @(negedge aclk);
    while (clk_out === 1'b1) @(negedge aclk);
    p = n_cyc - c0;
  endtask
  task automatic set_enable(input logic en);
    @(posedge aclk);
    clock_enable <= en;
  endtask
  task automatic wait_idle(input logic inv);
    logic [31:0] d;
    logic [1:0] r;
    do axi_rd(`CLKO_CFG_ADDR, d, r); while (d[7] !== 1'b1);
    @(negedge aclk);
    check("rest level", clk_out, inv);
    // Long enough for the checker's rest watch to arm
    repeat (210) @(negedge aclk);
    check("still at rest", clk_out, inv);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(12'h004, d, r);
    check("unmapped read resp", r, `CLKO_RESP_SLVERR);
    check("unmapped read data", d, 32'h0000_0000);
    axi_wr(12'h000, 8'hff, r);
    check("unmapped write resp", r, `CLKO_RESP_SLVERR);
    axi_rd(`CLKO_CFG_ADDR, d, r);
    check("reset value", d, 32'h0000_0080);
    // Byte lane 0 off: the write answers OKAY and changes nothing
    s_axi_wstrb <= 4'h0;
    axi_wr(`CLKO_CFG_ADDR, 8'h5f, r);
    check("masked write resp", r, `CLKO_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axi_rd(`CLKO_CFG_ADDR, d, r);
    check("masked write kept", d, 32'h0000_0080);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      pin_select <= i[1:0];
      @(negedge aclk);
      check("pin route", pin_route, i);
    end
  endtask
  // Settings go in before the enable, as software is told to do
  task automatic t_div(input logic [4:0] n, input logic sym, inv);
    logic [31:0] p, h, ne, lo;
    logic [1:0] r;
    ne = (n < 5'h02) ? 1 : n;
    lo = ne / 2;
    axi_wr(`CLKO_CFG_ADDR, {1'b0, inv, sym, n}, r);
    repeat (4) @(negedge aclk);
    check("stopped level", clk_out, inv);
    set_enable(1'b1);
    measure(p, h);
    check("period", p, 25 * ne, 2);
    check("high x2", 2 * h, (n < 5'h02) ? 25 : (sym && ne[0]) ? 25 * ne
      : 50 * (inv ? lo : ne - lo), 8);
    set_enable(1'b0);
    wait_idle(inv);
  endtask
  task automatic t_bound();
    logic [31:0] c0, p, h, d;
    logic [1:0] r;
    axi_wr(`CLKO_CFG_ADDR, 8'h1f, r);
    set_enable(1'b1);
    wait_rise();
    axi_rd(`CLKO_CFG_ADDR, d, r);
    check("busy bit", d[7], 1'b0);
    wait_rise();
    c0 = n_cyc;
    set_enable(1'b0);
    fall_time(c0, p);
    check("last high phase", p, 66, 4);
    wait_idle(1'b0);
    set_enable(1'b1);
    wait_rise();
    c0 = n_cyc;
    axi_wr(`CLKO_CFG_ADDR, 8'h02, r);
    fall_time(c0, p);
    check("high kept", p, 66, 4);
    measure(p, h);
    check("new period", p, 50, 2);
    axi_wr(`CLKO_CFG_ADDR, 8'h1f, r);
    // The first rise may still be a short period; the second is long
    wait_rise();
    wait_rise();
    c0 = n_cyc;
    axi_wr(`CLKO_CFG_ADDR, 8'h83, r);
    fall_time(c0, p);
    check("cut high", p, 6, 6);
    measure(p, h);
    check("period after clear", p, 75, 2);
    set_enable(1'b0);
    wait_idle(1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_div(5'd0, 1'b0, 1'b0);
    t_div(5'd1, 1'b0, 1'b1);
    t_div(5'd2, 1'b0, 1'b0);
    t_div(5'd3, 1'b0, 1'b0);
    t_div(5'd3, 1'b0, 1'b1);
    t_div(5'd3, 1'b1, 1'b0);
    t_div(5'd5, 1'b1, 1'b1);
    t_div(5'd6, 1'b1, 1'b0);
    t_div(5'd31, 1'b0, 1'b0);
    t_bound();
    give_verdict();
  end
endmodule // test_programmable_clock_output_divider
bind clko_divider clko_divider_checker chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .clock_enable, .pin_select, .clk_out, .pin_route);
`default_nettype wire

// >>> hw/clko_divider.sv
// Programmable clock output divider with its AXI4-Lite config register
//
// Operation
// - Writing one to clear resets the counter and forces output to the invert bit's rest level
// - Clear is a single pulse taken from a flop on the register write
// - Reading the clear bit position returns one when the divider is idle
// - Clear abandons the current period so a new factor applies at once
// - Clear plus new factor in one write clears and adopts it together
// - Inversion sits last, right before the output, inverting stop level
// - Disabled output rests at the invert bit's value
// - Invert should be set before enabling; later changes act at once
// - Symmetry bit gives near one-to-one duty for every factor
// - Symmetric output combines two flops on opposite oscillator phases
// - Factors zero and one pass the oscillator; larger ones divide by it
// - Without symmetry output is one flop; odd low phase one cycle shorter
// - Dropping the master enable finishes the period, then stops and idles
// - Factor writable anytime; applied at the next period boundary, or at once by a clear
// - Enable gates the waveform only; two-bit pin select routes it
// - Output derives from the 24 MHz oscillator, not the system divider
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "clko_params.svh"
module clko_divider (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire clko_pkg::clko_addr_t s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire clko_pkg::clko_addr_t s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Port setup bits, from the same clock domain
  input wire logic clock_enable,
  input wire logic [1:0] pin_select,
  // Pin side
  output logic clk_out,
  output logic [1:0] pin_route
);
  import clko_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Register bus

  logic aw_have_ff;
  logic w_have_ff;
  clko_addr_t awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wstrb0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic commit;
  logic inv_ff;
  logic sym_ff;
  clko_div_t div_ff;
  logic clr_pulse_ff;
  logic idle_ff;

  // Word decode shared by the read and write paths
  function automatic logic cfg_hit(input clko_addr_t addr);
    cfg_hit = (addr[11:2] == 10'(`CLKO_CFG_INDEX));
  endfunction

  // One write at a time: neither channel is taken while a response waits
  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = !w_have_ff && !bvalid_ff;
  assign commit = aw_have_ff && w_have_ff;

  // Address and data are caught in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= '0;
      wbyte_ff <= '0;
      wstrb0_ff <= 1'b0;
    end else if (commit) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wbyte_ff <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `CLKO_RESP_OKAY;
    end else if (commit) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= cfg_hit(awaddr_ff) ? `CLKO_RESP_OKAY : `CLKO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Stored settings; the clear bit is never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inv_ff <= `CLKO_BIT_RST;
      sym_ff <= `CLKO_BIT_RST;
      div_ff <= `CLKO_DIV_RST;
    end else if (commit && wstrb0_ff && cfg_hit(awaddr_ff)) begin
      inv_ff <= wbyte_ff[`CLKO_INV_BIT];
      sym_ff <= wbyte_ff[`CLKO_SYM_BIT];
      div_ff <= wbyte_ff[`CLKO_DIV_MSB:`CLKO_DIV_LSB];
    end
  end

  // Clear pulse from a flop, aligned with the settings update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_pulse_ff <= 1'b0;
    end else begin
      clr_pulse_ff <= commit && wstrb0_ff && cfg_hit(awaddr_ff) &&
                      wbyte_ff[`CLKO_CLR_BIT];
    end
  end

  // Read channel; idle appears in the clear bit position
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= `CLKO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      if (cfg_hit(s_axi_araddr)) begin
        rdata_ff <= {`CLKO_ZERO24, idle_ff, inv_ff, sym_ff, div_ff};
        rresp_ff <= `CLKO_RESP_OKAY;
      end else begin
        rdata_ff <= '0;
        rresp_ff <= `CLKO_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  //////////////////////////////////////////////////////////////////////////
  // Divider core

  logic half_tick;
  logic osc_level;
  logic rise_tick;
  logic fall_tick;
  logic run_ff;
  logic nxt_run;
  clko_div_t cnt_ff;
  clko_div_t nxt_cnt;
  clko_div_t act_div_ff;
  clko_div_t nxt_act_div;
  logic q_ff;
  logic sym_q;
  logic gen;
  logic out_ff;

  // Oscillator reference, independent of any system clock divider
  clko_osc_tick u_osc (
    .aclk(aclk),
    .aresetn(aresetn),
    .half_tick(half_tick),
    .osc_level(osc_level)
  );

  // A tick while low starts an oscillator high phase, and vice versa
  assign rise_tick = half_tick && !osc_level;
  assign fall_tick = half_tick && osc_level;

  // Last count of a period; factors 0 and 1 make every period one long
  function automatic clko_div_t last_cnt(input clko_div_t d);
    last_cnt = (d <= `CLKO_CNT_ONE) ? `CLKO_CNT_RST : 5'(d - 5'd1);
  endfunction

  // Low phase first, floor(N/2) long, so odd factors run high longer
  function automatic logic high_phase(input clko_div_t c, input clko_div_t d);
    high_phase = (c >= (d >> 1));
  endfunction

  // Period sequencing; a new factor is only adopted at a period start
  always_comb begin
    nxt_run = run_ff;
    nxt_cnt = cnt_ff;
    nxt_act_div = act_div_ff;
    if (!run_ff) begin
      if (clock_enable) begin
        nxt_run = 1'b1;
        nxt_cnt = `CLKO_CNT_RST;
        nxt_act_div = div_ff;
      end
    end else if (cnt_ff == last_cnt(act_div_ff)) begin
      if (!clock_enable) begin
        nxt_run = 1'b0;
        nxt_cnt = `CLKO_CNT_RST;
      end else begin
        nxt_cnt = `CLKO_CNT_RST;
        nxt_act_div = div_ff;
      end
    end else begin
      nxt_cnt = 5'(cnt_ff + 5'd1);
    end
  end

  // Clear wins over the tick: counter, phase flop and run all drop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= 1'b0;
      cnt_ff <= `CLKO_CNT_RST;
      act_div_ff <= `CLKO_DIV_RST;
      q_ff <= 1'b0;
    end else if (clr_pulse_ff) begin
      run_ff <= 1'b0;
      cnt_ff <= `CLKO_CNT_RST;
      act_div_ff <= div_ff;
      q_ff <= 1'b0;
    end else if (rise_tick) begin
      run_ff <= nxt_run;
      cnt_ff <= nxt_cnt;
      act_div_ff <= nxt_act_div;
      q_ff <= nxt_run && high_phase(nxt_cnt, nxt_act_div);
    end
  end

  // Second flop on the opposite oscillator phase
  clko_sym_combine u_sym (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(clr_pulse_ff),
    .fall_tick(fall_tick),
    .rise_q(q_ff),
    .sym_q(sym_q)
  );

  // Waveform select; bypass follows the oscillator for whole periods
  always_comb begin
    if (!run_ff) begin
      gen = 1'b0;
    end else if (act_div_ff <= `CLKO_CNT_ONE) begin
      gen = osc_level;
    end else if (sym_ff && act_div_ff[0]) begin
      gen = sym_q;
    end else begin
      gen = q_ff;
    end
  end

  // Inverter last, so the stopped level follows it; a mid-run change of
  // invert acts at once and may leave a short pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= gen ^ inv_ff;
    end
  end

  // Idle held in a flop before it reaches the read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_ff <= 1'b1;
    end else begin
      idle_ff <= !run_ff;
    end
  end

  // Routing is independent of the enable; both pins may carry the clock
  assign pin_route = pin_select;
  assign clk_out = out_ff;
endmodule // clko_divider
`default_nettype wire

// >>> hw/clko_osc_tick.sv
// Half-period tick generator standing in for the 24 MHz oscillator
`timescale 1ns/100ps
`default_nettype none
`include "clko_params.svh"
module clko_osc_tick (
  input wire logic aclk,
  input wire logic aresetn,
  output logic half_tick,
  output logic osc_level
);
  import clko_pkg::*;
  logic [26:0] acc_ff;
  logic [26:0] nxt_acc;
  logic [27:0] sum;
  clko_osc_e lvl_ff;

  // Fractional accumulator: 48 MHz ticks on average from 100 MHz, so
  // each oscillator half period jitters by one aclk cycle
  always_comb begin
    sum = {1'b0, acc_ff} + {1'b0, `CLKO_ACC_STEP};
    if (sum >= {1'b0, `CLKO_ACLK_HZ}) begin
      nxt_acc = 27'(sum - {1'b0, `CLKO_ACLK_HZ});
      half_tick = 1'b1;
    end else begin
      nxt_acc = sum[26:0];
      half_tick = 1'b0;
    end
  end

  // Accumulator and oscillator level, toggled on every half tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= `CLKO_ACC_RST;
      lvl_ff <= CLKO_OSC_LOW;
    end else begin
      acc_ff <= nxt_acc;
      if (half_tick) begin
        lvl_ff <= (lvl_ff == CLKO_OSC_LOW) ? CLKO_OSC_HIGH : CLKO_OSC_LOW;
      end
    end
  end

  assign osc_level = (lvl_ff == CLKO_OSC_HIGH);
endmodule // clko_osc_tick
`default_nettype wire

// >>> hw/clko_params.svh
// Constants of the programmable clock output divider
`ifndef CLKO_PARAMS_SVH
`define CLKO_PARAMS_SVH
// Register index as printed, byte address four times it
`define CLKO_CFG_INDEX 12'h008_F
`define CLKO_CFG_ADDR 12'h023_C
`define CLKO_ADDR_W 12
// Configuration field positions
`define CLKO_CLR_BIT 7
`define CLKO_INV_BIT 6
`define CLKO_SYM_BIT 5
`define CLKO_DIV_MSB 4
`define CLKO_DIV_LSB 0
// Reset values
`define CLKO_DIV_RST 5'h0_0
`define CLKO_BIT_RST 1'b0
`define CLKO_ZERO24 24'h00_0000
// Rates in Hz; the half-period tick rate is twice the oscillator rate
`define CLKO_OSC_HZ 27'd24000000
`define CLKO_ACLK_HZ 27'd100000000
`define CLKO_ACC_STEP (`CLKO_OSC_HZ * 27'd2)
`define CLKO_ACC_RST 27'h000_0000
// Counter reset value and the divide-by-one boundary
`define CLKO_CNT_RST 5'h0_0
`define CLKO_CNT_ONE 5'h0_1
// AXI responses
`define CLKO_RESP_OKAY 2'h0
`define CLKO_RESP_SLVERR 2'h2
`endif

// >>> hw/clko_pkg.sv
// Types of the programmable clock output divider
package clko_pkg;
  typedef logic [4:0] clko_div_t;
  typedef logic [11:0] clko_addr_t;
  typedef enum logic {
    CLKO_OSC_LOW,
    CLKO_OSC_HIGH
  } clko_osc_e;
endpackage

// >>> hw/clko_sym_combine.sv
// Second-phase flop that evens out the duty cycle for odd factors
`timescale 1ns/100ps
`default_nettype none
module clko_sym_combine (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic fall_tick,
  input wire logic rise_q,
  output logic sym_q
);
  logic fall_q_ff;

  // Samples the rising-phase flop half an oscillator period later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fall_q_ff <= 1'b0;
    end else if (clear) begin
      fall_q_ff <= 1'b0;
    end else if (fall_tick) begin
      fall_q_ff <= rise_q;
    end
  end

  // High phase shrinks by half a period; two flops mean a bit more jitter
  assign sym_q = rise_q & fall_q_ff;
endmodule // clko_sym_combine
`default_nettype wire
